// ### hdl/alu_pkg.sv
// Shared types and constants for the add/sub/logic datapath and its issuer
package alu_pkg;
  localparam int DATA_W = 32;
  localparam int REG_IDX_W = 4;
  localparam int SIGN_BIT = 31;
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [3:0] NO_DEST = 4'hF;
  localparam int HIGH_REG_BIT = 3;
  localparam int ALIGN_W = 2;
  localparam logic [31:0] IMM_SP_MAX = 32'h1FC;
  localparam logic [31:0] IMM_BASE_MAX = 32'h3FC;
  localparam logic [31:0] IMM_SEP_MAX = 32'h7;
  localparam logic [31:0] IMM_SAME_MAX = 32'hFF;

  typedef enum logic [3:0] {
    op_add = 4'h0,
    op_add_flags = 4'h1,
    add_with_carry_op = 4'h2,
    op_sub = 4'h3,
    op_sub_flags = 4'h4,
    subtract_with_borrow_op = 4'h5,
    negate_op = 4'h6,
    bitwise_and_op = 4'h7,
    bitwise_or_op = 4'h8,
    bitwise_xor_op = 4'h9,
    bit_clear_op = 4'hA,
    op_push = 4'hB,
    op_pop = 4'hC
  } alu_op_t;

  typedef struct packed {
    logic neg;
    logic zero;
    logic carry;
    logic ovf;
  } flags_t;

  localparam flags_t FLAGS_RESET = '{neg: 1'b0, zero: 1'b0, carry: 1'b0, ovf: 1'b0};
endpackage : alu_pkg

// ### hdl/alu_if.sv
// Issue/result link between the instruction issuer and the datapath
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
  import alu_pkg::*;
  logic issue_valid;
  alu_pkg::alu_op_t op;
  logic [3:0] dest_reg;
  logic dest_given;
  logic [3:0] first_src_reg;
  logic [3:0] second_src_reg;
  logic [31:0] first_val;
  logic [31:0] second_val;
  logic use_imm;
  logic [31:0] imm;
  logic pop_has_pc;
  logic res_valid;
  logic [31:0] result;
  logic [3:0] res_dest;
  logic res_write;
  alu_pkg::flags_t flags;
  logic branch_valid;
  logic [31:0] branch_target;

  modport datapath (
    input issue_valid, op, dest_reg, dest_given, first_src_reg, second_src_reg,
    input first_val, second_val, use_imm, imm, pop_has_pc,
    output res_valid, result, res_dest, res_write, flags, branch_valid, branch_target
  );
  modport issuer (
    output issue_valid, op, dest_reg, dest_given, first_src_reg, second_src_reg,
    output first_val, second_val, use_imm, imm, pop_has_pc,
    input res_valid, result, res_dest, res_write, flags, branch_valid, branch_target
  );
endinterface : alu_if
`default_nettype wire

// ### hdl/alu_adder.sv
// 32-bit adder with carry-in, carry-out and signed overflow
`timescale 1ns/100ps
`default_nettype none
module alu_adder (
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic cin_i,
  output logic [31:0] sum_o,
  output logic cout_o,
  output logic ovf_o
);
  import alu_pkg::*;
  logic [32:0] wide;
  always_comb begin
    wide = {1'b0, a_i} + {1'b0, b_i} + {32'h0, cin_i};
  end
  assign sum_o = wide[31:0];
  assign cout_o = wide[32];
  // Overflow when both inputs share a sign the sum lacks
  assign ovf_o = (a_i[SIGN_BIT] == b_i[SIGN_BIT]) && (sum_o[SIGN_BIT] != a_i[SIGN_BIT]);
endmodule : alu_adder
`default_nettype wire

// ### hdl/alu_datapath.sv
// Integer add/subtract/logic datapath holding the condition flags
//
// Contract
// - Push and pop keep all flags
// - Pop with PC branches to popped value
// - Add with carry writes, sets NZCV
// - Plain add writes sum, flags untouched
// - Flag-setting add equals add, sets NZCV
// - Negate computes zero minus first, sets NZCV
// - Subtract with borrow deducts one when carry set
// - Flag-setting subtract equals subtract, sets NZCV
// - Missing destination means first source
// - Carry ops use low regs, dest equals first
// - Register add: dest equals first, not both PC
// - SP/PC immediates bounded, multiples of four
// - Flag add/sub immediate ranges per destination form
// - Logic ops bitwise across 32 bits
// - Bit clear Bitwise_and_op with inverted second
// - Logic ops set NZ, keep CV
// - Logic ops low regs, dest equals first
// - Software chains carry for wide arithmetic
`timescale 1ns/100ps
`default_nettype none
module alu_datapath (
  input wire logic mclk_i,
  input wire logic rstn_i,
  alu_if.datapath bus,
  output alu_pkg::flags_t flags_o
);
  import alu_pkg::*;

  logic [31:0] operand_b;
  logic [31:0] add_a;
  logic [31:0] add_b;
  logic add_cin;
  logic [31:0] sum;
  logic cout;
  logic ovf;
  logic [31:0] logic_res;
  logic [31:0] next_result;
  logic arith_op;
  logic logic_op;
  logic write_op;
  logic pop_branch;
  flags_t next_flags;

  assign operand_b = bus.use_imm ? bus.imm : bus.second_val;

  // Subtraction is a + ~b + carry-in, so carry out reads as not-borrow
  always_comb begin
    add_a = bus.first_val;
    add_b = operand_b;
    add_cin = 1'b0;
    unique case (bus.op)
      add_with_carry_op: add_cin = flags_o.carry;
      op_sub, op_sub_flags: begin
        add_b = ~operand_b;
        add_cin = 1'b1;
      end
      subtract_with_borrow_op: begin
        add_b = ~operand_b;
        // Extra one deducted while carry is set
        add_cin = ~flags_o.carry;
      end
      // Zero minus first; a borrow shows as carry clear
      negate_op: begin
        add_a = '0;
        add_b = ~bus.first_val;
        add_cin = 1'b1;
      end
      default: ;
    endcase
  end

  // One shared adder serves every arithmetic form
  alu_adder u_adder (
    .a_i(add_a),
    .b_i(add_b),
    .cin_i(add_cin),
    .sum_o(sum),
    .cout_o(cout),
    .ovf_o(ovf)
  );

  // Logic ops never take the immediate path
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_bit
      always_comb begin
        unique case (bus.op)
          bitwise_and_op: logic_res[gi] = bus.first_val[gi] & bus.second_val[gi];
          bitwise_or_op: logic_res[gi] = bus.first_val[gi] | bus.second_val[gi];
          bitwise_xor_op: logic_res[gi] = bus.first_val[gi] ^ bus.second_val[gi];
          bit_clear_op: logic_res[gi] = bus.first_val[gi] & ~bus.second_val[gi];
          default: logic_res[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Codes past the pop command are unused and decode as a flag-keeping no-op
  always_comb begin
    arith_op = 1'b0;
    logic_op = 1'b0;
    write_op = 1'b1;
    unique case (bus.op)
      add_with_carry_op, op_add_flags, op_sub_flags,
      subtract_with_borrow_op, negate_op: begin
        arith_op = 1'b1;
      end
      bitwise_and_op, bitwise_or_op, bitwise_xor_op, bit_clear_op: begin
        logic_op = 1'b1;
      end
      op_push, op_pop: begin
        write_op = 1'b0;
      end
      op_add, op_sub: begin
        write_op = 1'b1;
      end
      default: begin
        write_op = 1'b0;
      end
    endcase
  end

  assign next_result = logic_op ? logic_res : sum;

  always_comb begin
    next_flags = flags_o;
    if (arith_op) begin
      next_flags.neg = next_result[SIGN_BIT];
      next_flags.zero = (next_result == '0);
      next_flags.carry = cout;
      next_flags.ovf = ovf;
    end else if (logic_op) begin
      next_flags.neg = next_result[SIGN_BIT];
      next_flags.zero = (next_result == '0);
    end
    // Push, pop, plain add and plain subtract keep every flag
  end

  // Refused forms never raise issue_valid, so they cannot touch the flags
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      flags_o <= FLAGS_RESET;
    end else if (bus.issue_valid) begin
      flags_o <= next_flags;
    end
  end

  // Result strobe follows every accepted issue by one cycle
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.res_valid <= 1'b0;
    end else begin
      bus.res_valid <= bus.issue_valid;
    end
  end

  // Result, destination and write enable hold until the next issue
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.result <= '0;
    end else if (bus.issue_valid) begin
      bus.result <= write_op ? next_result : '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.res_dest <= '0;
    end else if (bus.issue_valid) begin
      bus.res_dest <= bus.dest_given ? bus.dest_reg : bus.first_src_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.res_write <= 1'b0;
    end else if (bus.issue_valid) begin
      bus.res_write <= write_op;
    end
  end

  // Pop data arrives as second_val once the pop has finished loading
  assign pop_branch = bus.issue_valid && bus.op == op_pop && bus.pop_has_pc;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.branch_valid <= 1'b0;
    end else begin
      bus.branch_valid <= pop_branch;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.branch_target <= '0;
    end else if (pop_branch) begin
      bus.branch_target <= bus.second_val;
    end
  end

  assign bus.flags = flags_o;
endmodule : alu_datapath
`default_nettype wire

// ### hdl/alu_issuer.sv
// Issuer end: registers requests and mirrors results back to the user
`timescale 1ns/100ps
`default_nettype none
module alu_issuer (
  input wire logic mclk_i,
  input wire logic rstn_i,
  alu_if.issuer bus,
  input wire logic req_valid_i,
  input wire alu_pkg::alu_op_t req_op_i,
  input wire logic [3:0] req_dest_i,
  input wire logic req_dest_given_i,
  input wire logic [3:0] req_first_i,
  input wire logic [3:0] req_second_i,
  input wire logic [31:0] req_first_val_i,
  input wire logic [31:0] req_second_val_i,
  input wire logic req_use_imm_i,
  input wire logic [31:0] req_imm_i,
  input wire logic req_pop_pc_i,
  output logic req_illegal_o,
  output logic done_o,
  output logic [31:0] result_o,
  output logic [3:0] result_dest_o,
  output logic result_write_o,
  output alu_pkg::flags_t flags_o,
  output logic branch_o,
  output logic [31:0] branch_target_o
);
  import alu_pkg::*;
  logic low_ok;
  logic same_ok;
  logic legal;

  // Operand forms the issuer must respect; illegal ones are dropped
  always_comb begin
    low_ok = !req_dest_i[HIGH_REG_BIT] && !req_first_i[HIGH_REG_BIT]
             && (req_use_imm_i || !req_second_i[HIGH_REG_BIT]);
    same_ok = !req_dest_given_i || req_dest_i == req_first_i;
    legal = 1'b1;
    unique case (req_op_i)
      add_with_carry_op, subtract_with_borrow_op,
      bitwise_and_op, bitwise_or_op, bitwise_xor_op, bit_clear_op:
        legal = low_ok && same_ok && !req_use_imm_i;
      op_add: begin
        if (!req_use_imm_i) begin
          legal = same_ok && !(req_first_i == REG_PC && req_second_i == REG_PC);
        end else if (req_first_i == REG_SP && (!req_dest_given_i || req_dest_i == REG_SP)) begin
          legal = req_imm_i <= IMM_SP_MAX && req_imm_i[ALIGN_W-1:0] == '0;
        end else begin
          legal = (req_first_i == REG_SP || req_first_i == REG_PC)
                  && !req_dest_i[HIGH_REG_BIT]
                  && req_imm_i <= IMM_BASE_MAX && req_imm_i[ALIGN_W-1:0] == '0;
        end
      end
      op_sub: legal = req_use_imm_i && req_first_i == REG_SP && same_ok
                      && req_imm_i <= IMM_SP_MAX && req_imm_i[ALIGN_W-1:0] == '0;
      op_add_flags, op_sub_flags:
        legal = low_ok && (!req_use_imm_i || req_imm_i <= IMM_SEP_MAX
                || (same_ok && req_imm_i <= IMM_SAME_MAX));
      negate_op: legal = low_ok;
      default: legal = 1'b1;
    endcase
  end

  // Multiword chaining is left to software sequencing
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus.issue_valid <= 1'b0;
      bus.op <= op_add;
      bus.dest_reg <= '0;
      bus.dest_given <= 1'b0;
      bus.first_src_reg <= '0;
      bus.second_src_reg <= '0;
      bus.first_val <= '0;
      bus.second_val <= '0;
      bus.use_imm <= 1'b0;
      bus.imm <= '0;
      bus.pop_has_pc <= 1'b0;
      req_illegal_o <= 1'b0;
    end else begin
      bus.issue_valid <= req_valid_i && legal;
      req_illegal_o <= req_valid_i && !legal;
      bus.op <= req_op_i;
      bus.dest_reg <= req_dest_i;
      bus.dest_given <= req_dest_given_i;
      bus.first_src_reg <= req_first_i;
      bus.second_src_reg <= req_second_i;
      bus.first_val <= req_first_val_i;
      bus.second_val <= req_second_val_i;
      bus.use_imm <= req_use_imm_i;
      bus.imm <= req_imm_i;
      bus.pop_has_pc <= req_pop_pc_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      result_o <= '0;
      result_dest_o <= '0;
      result_write_o <= 1'b0;
      flags_o <= FLAGS_RESET;
      branch_o <= 1'b0;
      branch_target_o <= '0;
    end else begin
      done_o <= bus.res_valid;
      result_o <= bus.result;
      result_dest_o <= bus.res_dest;
      result_write_o <= bus.res_valid && bus.res_write;
      flags_o <= bus.flags;
      branch_o <= bus.branch_valid;
      branch_target_o <= bus.branch_target;
    end
  end
endmodule : alu_issuer
`default_nettype wire

// ### tb/alu_link_sva.sv
// Timing and arithmetic checks on the issuer/datapath link
`timescale 1ns/100ps
`default_nettype none
module alu_link_sva (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic issue_valid,
  input wire alu_pkg::alu_op_t op,
  input wire logic dest_given,
  input wire logic [3:0] first_src_reg,
  input wire logic [31:0] first_val,
  input wire logic [31:0] second_val,
  input wire logic use_imm,
  input wire logic [31:0] imm,
  input wire logic pop_has_pc,
  input wire logic res_valid,
  input wire logic [31:0] result,
  input wire logic [3:0] res_dest,
  input wire logic res_write,
  input wire alu_pkg::flags_t flags,
  input wire logic branch_valid,
  input wire logic [31:0] branch_target
);
  import alu_pkg::*;
  logic [31:0] opb;
  logic [32:0] add33;
  logic [32:0] adc33;
  logic [32:0] sbc33;
  logic [31:0] neg;
  logic [31:0] bic;
  logic [1:0] cv;
  logic ovf_add;
  assign opb = use_imm ? imm : second_val;
  assign add33 = {1'b0, first_val} + {1'b0, opb};
  assign adc33 = {1'b0, first_val} + {1'b0, second_val} + {32'h0, flags.carry};
  // Set carry means one extra off, so carry-in is its inverse
  assign sbc33 = {1'b0, first_val} + {1'b0, ~second_val} + {32'h0, ~flags.carry};
  assign neg = 32'h0 - first_val;
  assign bic = first_val & ~second_val;
  assign cv = {flags.carry, flags.ovf};
  assign ovf_add = (first_val[31] == opb[31]) && (add33[31] != first_val[31]);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  AST_RES_LAT: assert property (issue_valid |=> res_valid)
    else $error("result did not follow issue");
  AST_KEEP: assert property (
    issue_valid && op inside {op_add, op_sub, op_push, op_pop} |=> $stable(flags))
    else $error("flags changed by a non-flag op");
  AST_BRANCH: assert property (
    issue_valid && op == op_pop && pop_has_pc |=> branch_valid && !res_write
    && branch_target == $past(second_val)) else $error("pop branch wrong");
  AST_ADC: assert property (
    issue_valid && op == add_with_carry_op |=> {flags.carry, result} == $past(adc33))
    else $error("add with carry wrong");
  AST_ADD: assert property (
    issue_valid && op == op_add |=> result == $past(add33[31:0]))
    else $error("plain add wrong");
  AST_ADDS: assert property (
    issue_valid && op == op_add_flags |=> {flags.carry, result} == $past(add33)
    && flags.ovf == $past(ovf_add) && flags.neg == result[31]
    && flags.zero == (result == 32'h0)) else $error("flag add wrong");
  AST_NEG: assert property (
    issue_valid && op == negate_op |=> result == $past(neg) && flags.neg == result[31])
    else $error("negate wrong");
  AST_SBC: assert property (
    issue_valid && op == subtract_with_borrow_op |=> {flags.carry, result} == $past(sbc33))
    else $error("subtract with borrow wrong");
  AST_LOGIC_CV: assert property (
    issue_valid && op inside {bitwise_and_op, bitwise_or_op, bitwise_xor_op, bit_clear_op}
    |=> $stable(cv) && flags.zero == (result == 32'h0)) else $error("logic flags wrong");
  AST_BIC: assert property (
    issue_valid && op == bit_clear_op |=> result == $past(bic)) else $error("bit clear wrong");
  AST_DEST: assert property (
    issue_valid && !dest_given && !(op inside {op_push, op_pop})
    |=> res_dest == $past(first_src_reg)) else $error("omitted destination wrong");
  COV_ADC: cover property (issue_valid && op == add_with_carry_op);
  COV_BRANCH: cover property (branch_valid);
  COV_BIC: cover property (issue_valid && op == bit_clear_op);
endmodule : alu_link_sva
`default_nettype wire

// ### tb/tb_integer_add_sub_logic_alu.sv
// Self-checking bench joining issuer and datapath
`timescale 1ns/100ps
`default_nettype none
module tb_integer_add_sub_logic_alu;
  import alu_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req_valid_i = 1'b0;
  alu_op_t req_op_i = op_add;
  logic [3:0] req_dest_i = 4'h0;
  logic req_dest_given_i = 1'b0;
  logic [3:0] req_first_i = 4'h0;
  logic [3:0] req_second_i = 4'h0;
  logic [31:0] req_first_val_i = 32'h0;
  logic [31:0] req_second_val_i = 32'h0;
  logic req_use_imm_i = 1'b0;
  logic [31:0] req_imm_i = 32'h0;
  logic req_pop_pc_i = 1'b0;
  logic req_illegal_o, done_o, result_write_o, branch_o, ill;
  logic [31:0] result_o, branch_target_o;
  logic [3:0] result_dest_o;
  flags_t flags_o, dp_flags;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  alu_if bus ();
  alu_datapath i_alu_datapath (.mclk_i, .rstn_i, .bus, .flags_o(dp_flags));
  alu_issuer i_alu_issuer (.mclk_i, .rstn_i, .bus, .req_valid_i, .req_op_i, .req_dest_i,
    .req_dest_given_i, .req_first_i, .req_second_i, .req_first_val_i, .req_second_val_i,
    .req_use_imm_i, .req_imm_i, .req_pop_pc_i, .req_illegal_o, .done_o, .result_o,
    .result_dest_o, .result_write_o, .flags_o, .branch_o, .branch_target_o);
  alu_link_sva i_alu_link_sva (.mclk_i, .rstn_i, .issue_valid(bus.issue_valid), .op(bus.op),
    .dest_given(bus.dest_given), .first_src_reg(bus.first_src_reg), .first_val(bus.first_val),
    .second_val(bus.second_val), .use_imm(bus.use_imm), .imm(bus.imm),
    .pop_has_pc(bus.pop_has_pc), .res_valid(bus.res_valid), .result(bus.result),
    .res_dest(bus.res_dest), .res_write(bus.res_write), .flags(bus.flags),
    .branch_valid(bus.branch_valid), .branch_target(bus.branch_target));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Hang guard: a few hundred cycles are enough for every scenario
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic fl(input logic [3:0] e);
    chk("flags", {28'h0, flags_o}, {28'h0, e});
    chk("dp_flags", {28'h0, dp_flags}, {28'h0, e});
  endtask : fl
  task automatic r(input alu_op_t o, input logic [3:0] d, input logic g, input logic [3:0] f,
    input logic [3:0] s, input logic [31:0] a, input logic [31:0] b, input logic u,
    input logic [31:0] m, input logic p);
    int n;
    @(negedge mclk_i);
    {req_op_i, req_dest_i, req_dest_given_i, req_first_i, req_second_i, req_first_val_i,
      req_second_val_i, req_use_imm_i, req_imm_i, req_pop_pc_i} = {o, d, g, f, s, a, b, u, m, p};
    req_valid_i = 1'b1;
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && req_illegal_o !== 1'b1 && n < 8) begin
      @(negedge mclk_i);
      n++;
    end
    ill = req_illegal_o;
    chk("answered", n < 8, 1'b1);
  endtask : r
  task automatic rr(input alu_op_t o, input logic [3:0] f, input logic [3:0] s,
    input logic [31:0] a, input logic [31:0] b);
    r(o, f, 1'b1, f, s, a, b, 1'b0, 32'h0, 1'b0);
  endtask : rr
  task automatic t_add();
    r(op_add_flags, 4'h1, 1'b1, 4'h1, 4'h0, 32'h7FFFFFFF, 32'h0, 1'b1, 32'h1, 1'b0);
    chk("adds", result_o, 32'h80000000);
    fl(4'h9);
    rr(op_add, 4'h8, 4'h9, 32'h3, 32'h4);
    chk("add", result_o, 32'h7);
    fl(4'h9);
    rr(op_add_flags, 4'h2, 4'h3, 32'hFFFFFFFF, 32'h1);
    fl(4'h6);
    rr(add_with_carry_op, 4'h4, 4'h5, 32'h5, 32'h6);
    chk("add_with_carry_op", result_o, 32'hC);
    fl(4'h0);
  endtask : t_add
  task automatic t_sub();
    rr(op_sub_flags, 4'h1, 4'h2, 32'h5, 32'h5);
    fl(4'h6);
    rr(subtract_with_borrow_op, 4'h3, 4'h4, 32'hA, 32'h3);
    chk("subtract_with_borrow_op", result_o, 32'h6);
    fl(4'h2);
    rr(negate_op, 4'h5, 4'h0, 32'h1, 32'h0);
    chk("negate", result_o, 32'hFFFFFFFF);
    fl(4'h8);
    r(op_sub, REG_SP, 1'b1, REG_SP, 4'h0, 32'h64, 32'h0, 1'b1, 32'h8, 1'b0);
    chk("sub", result_o, 32'h5C);
    fl(4'h8);
  endtask : t_sub
  task automatic t_logic();
    alu_op_t lo[4];
    logic [31:0] ex[4];
    lo = '{bitwise_and_op, bitwise_or_op, bitwise_xor_op, bit_clear_op};
    ex = '{32'h00F0000F, 32'hFFF0F0FF, 32'hFF00F0F0, 32'hF00000F0};
    rr(op_add_flags, 4'h1, 4'h2, 32'h80000000, 32'h80000000);
    fl(4'h7);
    for (int i = 0; i < 4; i++) begin
      rr(lo[i], 4'h6, 4'h7, 32'hF0F000FF, 32'h0FF0F00F);
      chk("logic", result_o, ex[i]);
      fl({ex[i][31], ex[i] == 32'h0, 2'b11});
    end
  endtask : t_logic
  task automatic t_misc();
    r(op_add_flags, 4'h0, 1'b0, 4'h3, 4'h4, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b0, 32'h0, 1'b0);
    chk("dest", result_dest_o, 4'h3);
    chk("write", result_write_o, 1'b1);
    r(op_push, 4'h0, 1'b1, 4'h0, 4'h0, 32'h0, 32'h0, 1'b0, 32'h0, 1'b0);
    fl(4'hA);
    r(op_pop, 4'h0, 1'b1, 4'h0, 4'h0, 32'h0, 32'h101, 1'b0, 32'h0, 1'b1);
    chk("branch", branch_o, 1'b1);
    chk("target", branch_target_o, 32'h101);
    fl(4'hA);
  endtask : t_misc
  task automatic t_refuse();
    rr(add_with_carry_op, 4'h8, 4'h1, 32'h1, 32'h1);
    chk("ill_adc", ill, 1'b1);
    rr(op_add, REG_PC, REG_PC, 32'h1, 32'h1);
    chk("ill_pc", ill, 1'b1);
    r(op_add, REG_SP, 1'b1, REG_SP, 4'h0, 32'h0, 32'h0, 1'b1, 32'h200, 1'b0);
    chk("ill_sp", ill, 1'b1);
    r(op_add_flags, 4'h1, 1'b1, 4'h2, 4'h0, 32'h0, 32'h0, 1'b1, 32'h8, 1'b0);
    chk("ill_imm", ill, 1'b1);
    rr(bitwise_and_op, 4'h9, 4'h1, 32'h1, 32'h1);
    chk("ill_and", ill, 1'b1);
    fl(4'hA);
  endtask : t_refuse
  initial begin
    repeat (4) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_add();
    t_sub();
    t_logic();
    t_misc();
    t_refuse();
    final_report();
  end
endmodule : tb_integer_add_sub_logic_alu
`default_nettype wire
